//--- logic/action_timer.sv
// small down counter that times one wake action
`timescale 1ns/1ps
`include "aon_wake_map.svh"
module action_timer
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // control
  input  wire logic start_i,
  output logic      done_o
);
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic       done_d;
  logic       done_q;

  // load on start, count to zero, pulse done
  always_comb
  begin
    count_d = count_q;
    done_d  = 1'b0;
    if (start_i)
      count_d = `ACTION_CYCLES;
    else if (count_q != 4'h0)
    begin
      count_d = count_q - 4'h1;
      done_d  = (count_q == 4'h1);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_q <= 4'h0;
      done_q  <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      done_q  <= done_d;
    end
  end

  assign done_o = done_q;
endmodule

//--- logic/aon_wake_ctrl.sv
// always-on wake configuration registers and wake action sequencer
`timescale 1ns/1ps
`include "aon_wake_map.svh"
module aon_wake_ctrl
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // register access
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_busy_o,
  // wake events
  input  wire logic        wake_i,
  // always-on memory requests
  output logic             cfg_restore_o,
  output logic             cfg_default_o,
  output logic             cfg_save_o,
  output logic             cfg_upload_o,
  output logic             direct_read_o,
  output logic             direct_access_enable_o,
  // one-time memory loads
  output logic             id_load_o,
  output logic             trim_load_o,
  output logic [4:0]       otp_addr_o,
  output logic             microcode_copy_o,
  // operating controls
  output logic             long_preamble_parameter_set_o,
  output logic             clear_auto_sleep_o
);
  logic [15:0] wcfg_q, wcfg_d;
  logic [7:0]  cmd_q, cmd_d;
  aon_wake_pkg::wake_state_t state_q, state_d;
  logic [15:0] rdata_d;
  logic        busy_d, restore_d, default_d, save_d, upload_d, dread_d;
  logic        cmd_restore_d;
  logic        id_d, trim_d, ucode_d, lpre_d, clrsleep_d;
  logic [4:0]  otp_addr_d;
  logic        start;
  logic        done;
  logic        is_idle;

  // paces each wake action
  action_timer u_timer
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (start),
    .done_o  (done)
  );

  assign is_idle = (state_q == aon_wake_pkg::ST_IDLE);

  // ****************************************
  // wake sequencer
  // ****************************************
  always_comb
  begin
    state_d    = state_q;
    start      = 1'b0;
    restore_d  = 1'b0;
    default_d  = 1'b0;
    id_d       = 1'b0;
    trim_d     = 1'b0;
    ucode_d    = 1'b0;
    clrsleep_d = 1'b0;
    otp_addr_d = 5'h00;
    unique case (state_q)
      aon_wake_pkg::ST_IDLE:
        if (wake_i)
        begin
          state_d = aon_wake_pkg::ST_RESTORE;
          start   = 1'b1;
          restore_d = wcfg_q[`WCFG_RESTORE_BIT];
          default_d = ~wcfg_q[`WCFG_RESTORE_BIT];
          clrsleep_d = ~wcfg_q[`WCFG_KEEP_SLEEP_BIT];
        end
      aon_wake_pkg::ST_RESTORE:
        if (done)
        begin
          state_d = aon_wake_pkg::ST_ID;
          start   = 1'b1;
          id_d = wcfg_q[`WCFG_LOAD_ID_BIT];
        end
      aon_wake_pkg::ST_ID:
        if (done)
        begin
          state_d = aon_wake_pkg::ST_TRIM;
          start   = 1'b1;
          trim_d     = wcfg_q[`WCFG_TRIM_BIT];
          otp_addr_d = wcfg_q[`WCFG_TRIM_BIT] ? `TRIM_OTP_ADDR : 5'h00;
        end
      aon_wake_pkg::ST_TRIM:
        if (done)
        begin
          state_d = aon_wake_pkg::ST_UCODE;
          start   = 1'b1;
          ucode_d = wcfg_q[`WCFG_MICROCODE_BIT];
        end
      aon_wake_pkg::ST_UCODE:
        if (done)
          state_d = aon_wake_pkg::ST_FINISH;
      aon_wake_pkg::ST_FINISH:
        state_d = aon_wake_pkg::ST_IDLE;
      default:
        state_d = aon_wake_pkg::ST_IDLE;
    endcase
  end

  // ****************************************
  // registers and commands
  // ****************************************
  always_comb
  begin
    wcfg_d   = wcfg_q;
    cmd_d    = cmd_q;
    save_d   = 1'b0;
    upload_d = 1'b0;
    dread_d  = 1'b0;
    // command restore kept apart from the wake restore, one driver each
    cmd_restore_d = 1'b0;
    rdata_d  = 16'h0000;
    busy_d = ~(state_d == aon_wake_pkg::ST_IDLE);
    if (is_idle && !wake_i)
    begin
      if (cmd_q[`CMD_RESTORE_BIT])
      begin
        cmd_restore_d = 1'b1;
        cmd_d[`CMD_RESTORE_BIT] = 1'b0;
      end
      if (cmd_q[`CMD_SAVE_BIT])
      begin
        save_d   = 1'b1;
        upload_d = 1'b1;
        cmd_d[`CMD_SAVE_BIT] = 1'b0;
      end
      // upload stays set while idle and not waking, until host clears it
      upload_d = upload_d | cmd_q[`CMD_UPLOAD_BIT];
      if (cmd_q[`CMD_DREAD_BIT] && cmd_q[`CMD_DENAB_BIT])
      begin
        dread_d = 1'b1;
        cmd_d[`CMD_DREAD_BIT] = 1'b0;
      end
      if (reg_wr_i && reg_addr_i == `WAKE_CFG_OFFSET)
        wcfg_d = reg_wdata_i & `WCFG_WRITABLE_MASK;
      if (reg_wr_i && reg_addr_i == `AON_CMD_OFFSET)
        cmd_d = reg_wdata_i[7:0] & `CMD_WRITABLE_MASK;
      if (reg_rd_i && reg_addr_i == `WAKE_CFG_OFFSET)
        rdata_d = wcfg_q;
      else if (reg_rd_i && reg_addr_i == `AON_CMD_OFFSET)
        rdata_d = {8'h00, cmd_q};
    end
    lpre_d = wcfg_q[`WCFG_LONG_PRE_BIT];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q                       <= aon_wake_pkg::ST_IDLE;
      wcfg_q                        <= `WCFG_RESET;
      cmd_q                         <= `CMD_RESET;
      reg_rdata_o                   <= 16'h0000;
      reg_busy_o                    <= 1'b0;
      cfg_restore_o                 <= 1'b0;
      cfg_default_o                 <= 1'b0;
      cfg_save_o                    <= 1'b0;
      cfg_upload_o                  <= 1'b0;
      direct_read_o                 <= 1'b0;
      direct_access_enable_o        <= 1'b0;
      id_load_o                     <= 1'b0;
      trim_load_o                   <= 1'b0;
      otp_addr_o                    <= 5'h00;
      microcode_copy_o              <= 1'b0;
      long_preamble_parameter_set_o <= 1'b0;
      clear_auto_sleep_o            <= 1'b0;
    end
    else
    begin
      state_q                       <= state_d;
      wcfg_q                        <= wcfg_d;
      cmd_q                         <= cmd_d;
      reg_rdata_o                   <= rdata_d;
      reg_busy_o                    <= busy_d;
      cfg_restore_o                 <= restore_d | cmd_restore_d;
      cfg_default_o                 <= default_d;
      cfg_save_o                    <= save_d;
      cfg_upload_o                  <= upload_d;
      direct_read_o                 <= dread_d;
      direct_access_enable_o        <= cmd_d[`CMD_DENAB_BIT];
      id_load_o                     <= id_d;
      trim_load_o                   <= trim_d;
      otp_addr_o                    <= otp_addr_d;
      microcode_copy_o              <= ucode_d;
      long_preamble_parameter_set_o <= lpre_d;
      clear_auto_sleep_o            <= clrsleep_d;
    end
  end
endmodule

//--- logic/aon_wake_map.svh
// register offsets, field positions, reset values and timing counts of the wake block
`ifndef AON_WAKE_MAP_SVH
`define AON_WAKE_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define WAKE_CFG_OFFSET     8'h00
`define AON_CMD_OFFSET      8'h02
// ****************************************
// wake configuration fields
// ****************************************
`define WCFG_LOAD_ID_BIT    3
`define WCFG_RESTORE_BIT    6
`define WCFG_LONG_PRE_BIT   7
`define WCFG_KEEP_SLEEP_BIT 8
`define WCFG_MICROCODE_BIT  11
`define WCFG_TRIM_BIT       12
`define WCFG_WRITABLE_MASK  16'h19CB
`define WCFG_RESET          16'h0000
// ****************************************
// command fields and trim memory address
// ****************************************
`define CMD_RESTORE_BIT     0
`define CMD_SAVE_BIT        1
`define CMD_UPLOAD_BIT      2
`define CMD_DREAD_BIT       3
`define CMD_DENAB_BIT       7
`define CMD_WRITABLE_MASK   8'h8F
`define CMD_RESET           8'h00
`define TRIM_OTP_ADDR       5'h04
// ****************************************
// timing
// ****************************************
`define ACTION_CYCLES       4'h4
`endif

//--- logic/aon_wake_pkg.sv
// types of the always-on wake configuration block
package aon_wake_pkg;
  // wake sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_RESTORE = 6'h02,
    ST_ID      = 6'h04,
    ST_TRIM    = 6'h08,
    ST_UCODE   = 6'h10,
    ST_FINISH  = 6'h20
  } wake_state_t;
endpackage

//--- tb/aon_wake_chk.sv
// assertion checker for the wake configuration block
`timescale 1ns/1ps
module aon_wake_chk
(
  // watched ports
  input wire logic       clock_i, rst_i, wake_i, reg_busy_o,
  input wire logic       cfg_restore_o, cfg_default_o, clear_auto_sleep_o,
  input wire logic       id_load_o, trim_load_o, microcode_copy_o,
  input wire logic       cfg_save_o, cfg_upload_o, direct_read_o, direct_access_enable_o,
  input wire logic [4:0] otp_addr_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_wake; wake_i && !reg_busy_o; endsequence
  sequence s_busy; reg_busy_o [*8]; endsequence
  property p_busy; s_wake |=> s_busy; endproperty
  property p_cfg; s_wake |=> cfg_restore_o ^ cfg_default_o; endproperty
  property p_sleep; clear_auto_sleep_o |-> $past(wake_i); endproperty
  property p_id; id_load_o |-> $past(wake_i, 6); endproperty
  property p_trim; trim_load_o |-> $past(wake_i, 11) && otp_addr_o == 5'h04; endproperty
  property p_ucode; microcode_copy_o |-> $past(wake_i, 16); endproperty
  property p_save; cfg_save_o |-> cfg_upload_o; endproperty
  property p_dread; direct_read_o |-> direct_access_enable_o; endproperty
  a_busy: assert property (p_busy) else $error("busy not held");
  a_cfg: assert property (p_cfg) else $error("no restore or default");
  a_sleep: assert property (p_sleep) else $error("stray sleep clear");
  a_id: assert property (p_id) else $error("id load misplaced");
  a_trim: assert property (p_trim) else $error("trim load misplaced");
  a_ucode: assert property (p_ucode) else $error("microcode misplaced");
  a_save: assert property (p_save) else $error("save without upload");
  a_dread: assert property (p_dread) else $error("read without enable");
endmodule
bind aon_wake_ctrl aon_wake_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .wake_i(wake_i),
  .reg_busy_o(reg_busy_o), .cfg_restore_o(cfg_restore_o), .cfg_default_o(cfg_default_o),
  .clear_auto_sleep_o(clear_auto_sleep_o), .id_load_o(id_load_o), .trim_load_o(trim_load_o),
  .microcode_copy_o(microcode_copy_o), .cfg_save_o(cfg_save_o), .cfg_upload_o(cfg_upload_o),
  .direct_read_o(direct_read_o), .direct_access_enable_o(direct_access_enable_o), .otp_addr_o(otp_addr_o));

//--- tb/host_model.sv
// host processor model issuing register cycles
`timescale 1ns/1ps
module host_model
(
  // clock and read data
  input  wire logic        clock_i,
  input  wire logic [15:0] rdata_i,
  // request
  output logic             wr_o,
  output logic             rd_o,
  output logic [7:0]       addr_o,
  output logic [15:0]      wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  // write, taken at the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    #1;
    addr_o = a;
    wdata_o = (a == 8'h00) ? (d & 16'h19CB) : d;
    wr_o = 1'b1;
    @(posedge clock_i);
    #1;
    wr_o = 1'b0;
  endtask
  // read, data registered at the read edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clock_i);
    #1;
    d = rdata_i;
    rd_o = 1'b0;
  endtask
endmodule

//--- tb/testbench.sv
// testbench for the wake configuration block
`timescale 1ns/1ps
module testbench;
  logic        clock_i, rst_i, wake_i, wr, rd, busy, lp, den;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic [8:0]  pulse;
  logic [4:0]  otp, otp_seen;
  int          n_fail, checks, cyc, w, nbusy, at[9], cnt[9];
  aon_wake_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_busy_o(busy), .wake_i(wake_i),
    .cfg_restore_o(pulse[0]), .cfg_default_o(pulse[1]), .clear_auto_sleep_o(pulse[2]),
    .id_load_o(pulse[3]), .trim_load_o(pulse[4]), .microcode_copy_o(pulse[5]), .cfg_save_o(pulse[6]),
    .cfg_upload_o(pulse[7]), .direct_read_o(pulse[8]), .direct_access_enable_o(den), .otp_addr_o(otp),
    .long_preamble_parameter_set_o(lp));
  host_model u_host (.clock_i(clock_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  // ****************
  // clock, monitor
  // ****************
  initial
  begin
    clock_i = 0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    if (busy === 1'b1) nbusy++;
    for (int i = 0; i < 9; i++)
      if (pulse[i] === 1'b1)
      begin
        at[i] = cyc;
        cnt[i]++;
      end
    // address shown with the trim load
    if (pulse[4] === 1'b1)
      otp_seen = otp;
    if (cyc > 3000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  // wake pulse, then a write refused while busy
  task automatic wake();
    cnt = '{default:0};
    nbusy = 0;
    @(posedge clock_i);
    #1 wake_i = 1;
    @(posedge clock_i);
    #1 wake_i = 0;
    w = cyc;
    u_host.wr(8'h00, 16'h0000);
    repeat (20) @(posedge clock_i);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_all();
    u_host.wr(8'h00, 16'hFFFF);
    u_host.rd(8'h04, d);
    chk("unmapped", 0, d);
    chk("lp", 1, lp);
    wake();
    u_host.rd(8'h00, d);
    chk("wcfg", 16'h19CB, d);
    chk("busy", 21, nbusy);
    chk("restore", w + 1, at[0]);
    chk("id", w + 6, at[3]);
    chk("trim", w + 11, at[4]);
    chk("otp", 5'h04, otp_seen);
    chk("ucode", w + 16, at[5]);
    chk("keep", 0, cnt[2] + cnt[1]);
    $display("all actions test done");
  endtask
  task automatic t_none();
    u_host.wr(8'h00, 16'h0000);
    wake();
    chk("lp0", 0, lp);
    chk("default", w + 1, at[1]);
    chk("clr", w + 1, at[2]);
    chk("none", 0, cnt[0] + cnt[3] + cnt[4] + cnt[5]);
    $display("no actions test done");
  endtask
  task automatic t_cmd();
    u_host.rd(8'h02, d);
    chk("cmd rst", 0, d);
    u_host.wr(8'h02, 16'h0001);
    u_host.rd(8'h02, d);
    chk("cmd clr", 0, d);
    chk("restore", 1, cnt[0]);
    u_host.wr(8'h02, 16'h0002);
    u_host.wr(8'h02, 16'h0004);
    u_host.rd(8'h02, d);
    chk("upl reg", 16'h0004, d);
    chk("upl", 1, pulse[7]);
    chk("save", 1, cnt[6]);
    u_host.wr(8'h02, 16'h0088);
    u_host.rd(8'h02, d);
    chk("enab", 16'h0080, d);
    chk("den1", 1, den);
    chk("dread", 1, cnt[8]);
    u_host.wr(8'h02, 16'h0000);
    u_host.rd(8'h02, d);
    chk("den", 0, den);
    $display("command test done");
  endtask
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    {wake_i, n_fail, checks, cyc} = '0;
    rst_i = 1;
    repeat (5) @(posedge clock_i);
    #1 rst_i = 0;
    t_all();
    t_none();
    t_cmd();
    conclude();
  end
endmodule
